// File: core/t16_timer_regs.sv
/*
  Register layer of a 16-bit timer unit: counter, capture, three compare
  channels, shared high-byte latch, enable and flag registers.
  Assumes the core drives one read or write strobe per cycle, the prescaler
  supplies a one-cycle tick, and mode bits come from the control registers.
*/
`timescale 1ns/10ps
`default_nettype none
module t16_timer_regs #(
  parameter bit HAS_ALT_CAPTURE = 1'b1  // Comparator capture source present
) (
  input  wire logic                  clk_sys_i,     // System clock, 125 MHz
  input  wire logic                  rst_b_i,       // Async reset, active low
  input  wire t16_pkg::t16_bus_req_t bus_req_i,     // Register access
  output var  logic [7:0]            bus_rdata_o,   // Read byte, next cycle
  input  wire logic                  tick_i,        // Timer tick from prescaler
  input  wire logic [3:0]            mode_i,        // Waveform mode select
  input  wire logic                  cap_rise_i,    // Capture on rising edge
  input  wire logic                  capture_input_pin_i, // Capture pin
  input  wire logic                  cmp_out_i,     // Comparator output
  input  wire logic                  cmp_sel_i,     // Capture from comparator
  input  wire logic                  global_ie_i,   // Global interrupt enable
  input  wire logic [5:0]            vector_ack_i,  // Vector taken, per flag
  output var  logic [5:0]            irq_req_o,     // Interrupt requests
  output var  logic [2:0]            match_event_o  // Waveform match A,B,C
);

  // ==========================================================================
  // Local sizes
  localparam int unsigned PAD_W   = $bits(t16_pkg::BYTE_ZERO) - t16_pkg::FLG_W; // Unused bits
  localparam int unsigned SEL_PIN = 0;  // Synchroniser lane of the capture pin
  localparam int unsigned SEL_CMP = 1;  // Synchroniser lane of the comparator
  localparam int unsigned LANES   = 2;  // Asynchronous inputs synchronised

  // ==========================================================================
  // Register state
  logic [15:0]          count_reg;   // Counter
  logic [15:0]          count_next;
  t16_pkg::t16_dir_t    dir_reg;     // Count direction, dual-slope modes only
  t16_pkg::t16_dir_t    dir_next;
  logic [15:0]          cap_reg;     // Captured count
  logic [15:0]          cap_next;
  logic [7:0]           temp_reg;    // Shared high-byte latch
  logic [7:0]           temp_next;
  logic [7:0]           rdata_reg;   // Read byte
  logic [7:0]           rdata_next;
  logic [5:0]           en_reg;      // Interrupt enables
  logic [5:0]           en_next;
  logic [5:0]           flg_reg;     // Interrupt flags
  logic [5:0]           flg_next;
  logic [5:0]           irq_reg;     // Registered requests
  logic [5:0]           irq_next;
  logic [2:0]           mev_reg;     // Waveform match events A,B,C
  logic [2:0]           mev_next;
  logic                 block_reg;   // Compare blocked on next tick
  logic                 block_next;

  // ==========================================================================
  // Pin synchroniser
  logic [LANES-1:0]     sync1_reg;
  logic [LANES-1:0]     sync2_reg;
  logic [LANES-1:0]     sync3_reg;
  logic [LANES-1:0]     filt_reg;    // Level accepted once two stages agree
  logic [LANES-1:0]     filt_d_reg;  // Previous accepted level
  logic [LANES-1:0]     filt_next;

  // ==========================================================================
  // Decode wires
  logic                 wr_hi;
  logic                 cnt_commit;
  logic                 cap_commit;
  logic                 ma_load;
  logic                 mb_load;
  logic                 mc_load;
  logic                 en_write;
  logic                 flg_write;
  logic                 frc_wr;
  logic [15:0]          wr16_val;
  logic                 top_is_cap;
  logic                 top_is_ma;
  logic                 dual_slope;
  logic                 fast_pwm;
  logic                 non_pwm;
  logic                 top_8;
  logic                 top_9;
  logic                 top_10;
  logic [15:0]          top_val;
  logic                 at_top;
  logic                 at_bottom;
  logic [15:0]          up_step;
  logic [15:0]          down_step;
  logic [15:0]          ma_val;
  logic [15:0]          mb_val;
  logic [15:0]          mc_val;
  logic                 ma_hit;
  logic                 mb_hit;
  logic                 mc_hit;
  logic                 ma_set;
  logic                 mb_set;
  logic                 mc_set;
  logic                 cap_lvl;
  logic                 cap_prev;
  logic                 cap_edge;
  logic                 cap_evt;
  logic                 cap_set;
  logic                 wrap_set;
  logic [5:0]           set_vec;
  logic [5:0]           clr_vec;
  logic [2:0]           frc_vec;

  // ==========================================================================
  // Bus decode; a low-byte write commits the latch and the byte together
  assign wr_hi      = bus_req_i.wr && (bus_req_i.addr inside {t16_pkg::OFS_CNT_H,
                      t16_pkg::OFS_CAP_H, t16_pkg::OFS_MA_H, t16_pkg::OFS_MB_H,
                      t16_pkg::OFS_MC_H});
  assign cnt_commit = bus_req_i.wr && (bus_req_i.addr == t16_pkg::OFS_CNT_L);
  assign cap_commit = bus_req_i.wr && (bus_req_i.addr == t16_pkg::OFS_CAP_L);
  assign ma_load    = bus_req_i.wr && (bus_req_i.addr == t16_pkg::OFS_MA_L);
  assign mb_load    = bus_req_i.wr && (bus_req_i.addr == t16_pkg::OFS_MB_L);
  assign mc_load    = bus_req_i.wr && (bus_req_i.addr == t16_pkg::OFS_MC_L);
  assign en_write   = bus_req_i.wr && (bus_req_i.addr == t16_pkg::OFS_IRQ_EN);
  assign flg_write  = bus_req_i.wr && (bus_req_i.addr == t16_pkg::OFS_IRQ_FLG);
  assign frc_wr     = bus_req_i.wr && (bus_req_i.addr == t16_pkg::OFS_CTRL3) && non_pwm;
  assign wr16_val   = {temp_reg, bus_req_i.wdata};

  // ==========================================================================
  // Mode decode
  assign top_is_cap = mode_i inside {t16_pkg::MODE_PFC_CAP, t16_pkg::MODE_PC_CAP,
                      t16_pkg::MODE_CTC_CAP, t16_pkg::MODE_FAST_CAP};
  assign top_is_ma  = mode_i inside {t16_pkg::MODE_CTC_A, t16_pkg::MODE_PFC_A,
                      t16_pkg::MODE_PC_A, t16_pkg::MODE_FAST_A};
  assign dual_slope = mode_i inside {t16_pkg::MODE_PC8, t16_pkg::MODE_PC9,
                      t16_pkg::MODE_PC10, t16_pkg::MODE_PFC_CAP, t16_pkg::MODE_PFC_A,
                      t16_pkg::MODE_PC_CAP, t16_pkg::MODE_PC_A};
  assign fast_pwm   = mode_i inside {t16_pkg::MODE_FAST8, t16_pkg::MODE_FAST9,
                      t16_pkg::MODE_FAST10, t16_pkg::MODE_FAST_CAP, t16_pkg::MODE_FAST_A};
  assign non_pwm    = mode_i inside {t16_pkg::MODE_NORMAL, t16_pkg::MODE_CTC_A,
                      t16_pkg::MODE_CTC_CAP};
  assign top_8      = (mode_i == t16_pkg::MODE_PC8) || (mode_i == t16_pkg::MODE_FAST8);
  assign top_9      = (mode_i == t16_pkg::MODE_PC9) || (mode_i == t16_pkg::MODE_FAST9);
  assign top_10     = (mode_i == t16_pkg::MODE_PC10) || (mode_i == t16_pkg::MODE_FAST10);

  // Reserved codes fall through to the full range
  assign top_val    = top_is_cap ? cap_reg :
                      top_is_ma  ? ma_val :
                      top_8      ? t16_pkg::TOP_8BIT :
                      top_9      ? t16_pkg::TOP_9BIT :
                      top_10     ? t16_pkg::TOP_10BIT : t16_pkg::CNT_MAX;
  assign at_top     = (count_reg == top_val);
  assign at_bottom  = (count_reg == t16_pkg::CNT_BOTTOM);
  assign up_step    = count_reg + t16_pkg::CNT_ONE;
  assign down_step  = count_reg - t16_pkg::CNT_ONE;

  // ==========================================================================
  // Capture source and edge
  assign cap_lvl  = (HAS_ALT_CAPTURE && cmp_sel_i) ? filt_reg[SEL_CMP] : filt_reg[SEL_PIN];
  assign cap_prev = (HAS_ALT_CAPTURE && cmp_sel_i) ? filt_d_reg[SEL_CMP] : filt_d_reg[SEL_PIN];
  assign cap_edge = cap_rise_i ? (cap_lvl && !cap_prev) : (!cap_lvl && cap_prev);
  assign cap_evt  = cap_edge && !top_is_cap;
  assign cap_set  = cap_evt || (top_is_cap && tick_i && at_top);

  // Only the agreeing pair moves the level, so a one-cycle glitch is dropped
  assign filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));

  // ==========================================================================
  // Flags and requests; a set in the clearing cycle wins
  assign wrap_set = tick_i && ((non_pwm && (count_reg == t16_pkg::CNT_MAX)) ||
                    (fast_pwm && at_top) ||
                    (dual_slope && (dir_reg == t16_pkg::DIR_DOWN) && at_bottom));
  assign set_vec  = {cap_set, 1'b0, mc_set, mb_set, ma_set, wrap_set};
  assign clr_vec  = (flg_write ? bus_req_i.wdata[t16_pkg::FLG_W-1:0] : '0) | vector_ack_i;
  assign flg_next = ((flg_reg & ~clr_vec) | set_vec) & t16_pkg::FLG_VALID;
  assign en_next  = en_write ? (bus_req_i.wdata[t16_pkg::FLG_W-1:0] & t16_pkg::FLG_VALID)
                             : en_reg;
  assign irq_next = en_reg & flg_reg & {t16_pkg::FLG_W{global_ie_i}};

  // Forced strobes reach the waveform only, never a flag
  assign frc_vec  = {bus_req_i.wdata[t16_pkg::BIT_FRC_C], bus_req_i.wdata[t16_pkg::BIT_FRC_B],
                     bus_req_i.wdata[t16_pkg::BIT_FRC_A]} & {3{frc_wr}};
  assign mev_next = {mc_hit, mb_hit, ma_hit} | frc_vec;

  // A counter write arms the block; the next tick spends it
  assign block_next = cnt_commit ? 1'b1 : (tick_i ? 1'b0 : block_reg);

  // Capture beats a bus write landing in the same cycle
  assign cap_next = cap_evt ? count_reg : (cap_commit ? wr16_val : cap_reg);

  // ==========================================================================
  // Counter
  always_comb begin
    count_next = count_reg;
    dir_next   = dir_reg;
    if (cnt_commit) begin
      count_next = wr16_val;
    end else if (tick_i) begin
      if (dual_slope) begin
        case (dir_reg)
          t16_pkg::DIR_UP: begin
            if (at_top) begin
              dir_next   = t16_pkg::DIR_DOWN;
              count_next = down_step;
            end else begin
              count_next = up_step;
            end
          end
          t16_pkg::DIR_DOWN: begin
            if (at_bottom) begin
              dir_next   = t16_pkg::DIR_UP;
              count_next = up_step;
            end else begin
              count_next = down_step;
            end
          end
          default: begin
            dir_next   = t16_pkg::DIR_UP;
            count_next = t16_pkg::CNT_BOTTOM;
          end
        endcase
      end else begin
        dir_next = t16_pkg::DIR_UP;
        if (at_top) begin
          count_next = t16_pkg::CNT_BOTTOM;
        end else begin
          count_next = up_step;
        end
      end
    end
  end

  // ==========================================================================
  // Read mux; a low-byte read parks the high byte in the latch
  always_comb begin
    rdata_next = rdata_reg;
    temp_next  = temp_reg;
    if (wr_hi) begin
      temp_next = bus_req_i.wdata;
    end
    if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        t16_pkg::OFS_CNT_L: begin
          rdata_next = count_reg[7:0];
          temp_next  = count_reg[15:8];
        end
        t16_pkg::OFS_CAP_L: begin
          rdata_next = cap_reg[7:0];
          temp_next  = cap_reg[15:8];
        end
        t16_pkg::OFS_MA_L: begin
          rdata_next = ma_val[7:0];
          temp_next  = ma_val[15:8];
        end
        t16_pkg::OFS_MB_L: begin
          rdata_next = mb_val[7:0];
          temp_next  = mb_val[15:8];
        end
        t16_pkg::OFS_MC_L: begin
          rdata_next = mc_val[7:0];
          temp_next  = mc_val[15:8];
        end
        t16_pkg::OFS_CNT_H, t16_pkg::OFS_CAP_H, t16_pkg::OFS_MA_H,
        t16_pkg::OFS_MB_H, t16_pkg::OFS_MC_H: begin
          rdata_next = temp_reg;
        end
        t16_pkg::OFS_IRQ_EN: begin
          rdata_next = {{PAD_W{1'b0}}, en_reg};
        end
        t16_pkg::OFS_IRQ_FLG: begin
          rdata_next = {{PAD_W{1'b0}}, flg_reg};
        end
        default: begin
          rdata_next = t16_pkg::BYTE_ZERO; // Strobes and gaps read zero
        end
      endcase
    end
  end

  // ==========================================================================
  // Compare channels
  t16_match_chan u_chan_a (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .tick_i      (tick_i),
    .block_i     (block_reg),
    .count_i     (count_reg),
    .load_i      (ma_load),
    .load_val_i  (wr16_val),
    .match_val_o (ma_val),
    .hit_o       (ma_hit),
    .flag_set_o  (ma_set)
  );
  t16_match_chan u_chan_b (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .tick_i      (tick_i),
    .block_i     (block_reg),
    .count_i     (count_reg),
    .load_i      (mb_load),
    .load_val_i  (wr16_val),
    .match_val_o (mb_val),
    .hit_o       (mb_hit),
    .flag_set_o  (mb_set)
  );
  t16_match_chan u_chan_c (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .tick_i      (tick_i),
    .block_i     (block_reg),
    .count_i     (count_reg),
    .load_i      (mc_load),
    .load_val_i  (wr16_val),
    .match_val_o (mc_val),
    .hit_o       (mc_hit),
    .flag_set_o  (mc_set)
  );

  // ==========================================================================
  // Flip-flops
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_reg  <= '0;
      sync2_reg  <= '0;
      sync3_reg  <= '0;
      filt_reg   <= '0;
      filt_d_reg <= '0;
    end else begin
      sync1_reg  <= {cmp_out_i, capture_input_pin_i};
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      filt_reg   <= filt_next;
      filt_d_reg <= filt_reg;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_reg <= t16_pkg::CNT_BOTTOM;
      dir_reg   <= t16_pkg::DIR_UP;
      cap_reg   <= t16_pkg::CNT_BOTTOM;
      temp_reg  <= t16_pkg::BYTE_ZERO;
      block_reg <= 1'b0;
      en_reg    <= '0;
      flg_reg   <= '0;
    end else begin
      count_reg <= count_next;
      dir_reg   <= dir_next;
      cap_reg   <= cap_next;
      temp_reg  <= temp_next;
      block_reg <= block_next;
      en_reg    <= en_next;
      flg_reg   <= flg_next;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= t16_pkg::BYTE_ZERO;
      irq_reg   <= '0;
      mev_reg   <= '0;
    end else begin
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
      mev_reg   <= mev_next;
    end
  end

  assign bus_rdata_o   = rdata_reg;
  assign irq_req_o     = irq_reg;
  assign match_event_o = mev_reg;

  // ==========================================================================
  // Checks
  sequence seq_cnt_commit;
    bus_req_i.wr && (bus_req_i.addr == t16_pkg::OFS_CNT_L);
  endsequence

  cnt_commit_a : assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    seq_cnt_commit |=> (count_reg == $past(wr16_val)))
    else $error("counter did not take the latched word");
  cnt_block_a : assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    seq_cnt_commit |=> block_reg)
    else $error("counter write did not arm the compare block");
  match_flag_a : assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    ma_set |=> flg_reg[t16_pkg::BIT_MA])
    else $error("match flag A not set");
  force_flag_a : assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (frc_vec[0] && !ma_set && !flg_reg[t16_pkg::BIT_MA]) |=> !flg_reg[t16_pkg::BIT_MA])
    else $error("forced strobe set a match flag");
  cap_load_a : assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    cap_evt |=> (cap_reg == $past(count_reg)))
    else $error("capture did not load the count");
  vector_clr_a : assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (vector_ack_i[t16_pkg::BIT_CAP] && !cap_set) |=> !flg_reg[t16_pkg::BIT_CAP])
    else $error("vector did not clear the capture flag");
  irq_gate_a : assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !global_ie_i |=> (irq_req_o == '0))
    else $error("request raised with interrupts off");
endmodule : t16_timer_regs
`default_nettype wire

// File: inc/t16_pkg.sv
/*
  Constants, mode codes and bus carrier for the 16-bit timer register layer.
  Assumes one 8-bit register port from the processor core and one timer tick.
*/
`default_nettype none
package t16_pkg;

  // ==========================================================================
  // Register port
  typedef struct packed {
    logic [3:0] addr;   // Register index
    logic [7:0] wdata;  // Write byte
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
  } t16_bus_req_t;

  localparam logic [3:0] OFS_CNT_L   = 4'h0;
  localparam logic [3:0] OFS_CNT_H   = 4'h1;
  localparam logic [3:0] OFS_CAP_L   = 4'h2;
  localparam logic [3:0] OFS_CAP_H   = 4'h3;
  localparam logic [3:0] OFS_MA_L    = 4'h4;
  localparam logic [3:0] OFS_MA_H    = 4'h5;
  localparam logic [3:0] OFS_MB_L    = 4'h6;
  localparam logic [3:0] OFS_MB_H    = 4'h7;
  localparam logic [3:0] OFS_MC_L    = 4'h8;
  localparam logic [3:0] OFS_MC_H    = 4'h9;
  localparam logic [3:0] OFS_IRQ_EN  = 4'hA;
  localparam logic [3:0] OFS_IRQ_FLG = 4'hB;
  localparam logic [3:0] OFS_CTRL3   = 4'hC;

  // ==========================================================================
  // Field layout of enable and flag registers and of the CTRL3 force strobes
  localparam int unsigned BIT_WRAP = 0;
  localparam int unsigned BIT_MA   = 1;
  localparam int unsigned BIT_MB   = 2;
  localparam int unsigned BIT_MC   = 3;
  localparam int unsigned BIT_CAP  = 5;
  localparam int unsigned FLG_W    = 6;
  localparam logic [5:0]  FLG_VALID = 6'h2F;
  localparam int unsigned BIT_FRC_A = 7;
  localparam int unsigned BIT_FRC_B = 6;
  localparam int unsigned BIT_FRC_C = 5;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  // ==========================================================================
  // Counter values
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;

  // ==========================================================================
  // Waveform mode codes
  localparam logic [3:0] MODE_NORMAL   = 4'h0;
  localparam logic [3:0] MODE_PC8      = 4'h1;
  localparam logic [3:0] MODE_PC9      = 4'h2;
  localparam logic [3:0] MODE_PC10     = 4'h3;
  localparam logic [3:0] MODE_CTC_A    = 4'h4;
  localparam logic [3:0] MODE_FAST8    = 4'h5;
  localparam logic [3:0] MODE_FAST9    = 4'h6;
  localparam logic [3:0] MODE_FAST10   = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP  = 4'h8;
  localparam logic [3:0] MODE_PFC_A    = 4'h9;
  localparam logic [3:0] MODE_PC_CAP   = 4'hA;
  localparam logic [3:0] MODE_PC_A     = 4'hB;
  localparam logic [3:0] MODE_CTC_CAP  = 4'hC;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_A   = 4'hF;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } t16_dir_t;

endpackage : t16_pkg
`default_nettype wire

// File: core/t16_match_chan.sv
/*
  One compare channel: holds its match value, compares on each tick and
  raises the flag-set pulse one tick later. Assumes the tick is a one-cycle
  pulse on clk_sys_i and that loads come already paired by the latch.
*/
`timescale 1ns/10ps
`default_nettype none
module t16_match_chan (
  input  wire logic        clk_sys_i,   // System clock
  input  wire logic        rst_b_i,     // Async reset, active low
  input  wire logic        tick_i,      // Timer tick pulse
  input  wire logic        block_i,     // Suppress compare this tick
  input  wire logic [15:0] count_i,     // Current counter value
  input  wire logic        load_i,      // Commit new match value
  input  wire logic [15:0] load_val_i,  // Value to commit
  output var  logic [15:0] match_val_o, // Stored match value
  output var  logic        hit_o,       // Equality on this tick
  output var  logic        flag_set_o   // Flag set pulse, tick after hit
);
  logic pend_reg;

  assign hit_o      = tick_i && !block_i && (count_i == match_val_o);
  assign flag_set_o = tick_i && pend_reg;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      match_val_o <= t16_pkg::CNT_BOTTOM;
      pend_reg    <= 1'b0;
    end else begin
      if (load_i) begin
        match_val_o <= load_val_i;
      end
      if (tick_i) begin
        pend_reg <= hit_o;
      end
    end
  end

  // ==========================================================================
  // Checks
  sequence seq_equal_tick;
    tick_i && !block_i && (count_i == match_val_o);
  endsequence

  hit_pending_a : assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    seq_equal_tick |=> pend_reg)
    else $error("match pending not raised after equality");
  block_tick_a : assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (tick_i && block_i) |=> !pend_reg)
    else $error("blocked tick still produced a match");
endmodule : t16_match_chan
`default_nettype wire

// File: test/t16_core_model.sv
/* Processor core model driving byte cycles on the register port.
   Assumes read data is valid after the edge that takes the strobe. */
`timescale 1ns/10ps
`default_nettype none
module t16_core_model (
  input  wire logic                  clk_sys_i, // System clock
  output var  t16_pkg::t16_bus_req_t bus_req_o, // Register access
  input  wire logic [7:0]            rdata_i    // Read byte
);
  // ==========================================================================
  // Byte cycles; stale data is inverted so a late sample cannot pass
  initial bus_req_o = '0;
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #1 bus_req_o = '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_i) #1 bus_req_o = '{a, ~d, 1'b0, 1'b0};
  endtask : wr8
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i) #1 bus_req_o = '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys_i) #1 bus_req_o.rd = 1'b0;
    d = rdata_i;
  endtask : rd8
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr8(a + 4'h1, v[15:8]);
    wr8(a, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 4'h1, v[15:8]);
  endtask : rd16
endmodule : t16_core_model
`default_nettype wire

// File: test/test_timer16_counter_compare_capture_regs.sv
/* Self-checking bench for the timer register layer.
   Assumes the core model above; tick driven by hand, mode normal except MODE_CTC_CAP in t_top. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_timer16_counter_compare_capture_regs;
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, tick_i = 1'b0, pin = 1'b0, gie = 1'b0;
  logic [5:0] ack = 6'h00, irq;
  logic [7:0] rdata, b;
  logic [15:0] v;
  logic [3:0] mode = t16_pkg::MODE_NORMAL;
  logic [2:0] mev;
  t16_pkg::t16_bus_req_t req;
  int n_mismatch = 0, num_checks = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  t16_core_model u_core (.clk_sys_i(clk_sys_i), .bus_req_o(req), .rdata_i(rdata));
  t16_timer_regs u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus_req_i(req),
    .bus_rdata_o(rdata), .tick_i(tick_i), .mode_i(mode),
    .cap_rise_i(1'b1), .capture_input_pin_i(pin), .cmp_out_i(1'b0), .cmp_sel_i(1'b0),
    .global_ie_i(gie), .vector_ack_i(ack), .irq_req_o(irq), .match_event_o(mev));
  // ==========================================================================
  // Scenarios
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys_i) #1 tick_i = 1'b1;
      @(posedge clk_sys_i) #1 tick_i = 1'b0;
    end
  endtask : ticks
  task automatic t_reset();
    u_core.rd8(t16_pkg::OFS_IRQ_EN, b); `CHK("enable", 8'h00, b)
    u_core.rd8(t16_pkg::OFS_IRQ_FLG, b); `CHK("flags", 8'h00, b)
    u_core.wr16(t16_pkg::OFS_CNT_L, 16'hA55A);
    u_core.rd16(t16_pkg::OFS_CNT_L, v); `CHK("count", 16'hA55A, v)
  endtask : t_reset
  task automatic t_block_force();
    u_core.wr16(t16_pkg::OFS_MA_L, 16'h0020);
    u_core.wr16(t16_pkg::OFS_CNT_L, 16'h0020);
    ticks(3);
    u_core.wr8(t16_pkg::OFS_CTRL3, 8'h80);
    `CHK("force", 3'h1, mev)
    u_core.rd8(t16_pkg::OFS_IRQ_FLG, b); `CHK("blocked", 8'h00, b)
  endtask : t_block_force
  task automatic t_match();
    gie = 1'b1;
    u_core.wr8(t16_pkg::OFS_IRQ_EN, 8'h02);
    u_core.wr16(t16_pkg::OFS_MA_L, 16'h0010);
    u_core.wr16(t16_pkg::OFS_CNT_L, 16'h000E);
    ticks(4);
    u_core.rd8(t16_pkg::OFS_IRQ_FLG, b); `CHK("match", 8'h02, b)
    `CHK("irq", 1'b1, irq[t16_pkg::BIT_MA])
    u_core.wr8(t16_pkg::OFS_IRQ_FLG, 8'h02);
    u_core.rd8(t16_pkg::OFS_IRQ_FLG, b); `CHK("clear", 8'h00, b)
  endtask : t_match
  task automatic t_capture();
    u_core.wr16(t16_pkg::OFS_CNT_L, 16'h0300);
    @(posedge clk_sys_i) #1 pin = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    u_core.rd16(t16_pkg::OFS_CAP_L, v); `CHK("capture", 16'h0300, v)
    u_core.rd8(t16_pkg::OFS_IRQ_FLG, b); `CHK("capflag", 8'h20, b)
    @(posedge clk_sys_i) #1 ack = 6'h20;
    @(posedge clk_sys_i) #1 ack = 6'h00;
    u_core.rd8(t16_pkg::OFS_IRQ_FLG, b); `CHK("vector", 8'h00, b)
  endtask : t_capture
  task automatic t_top();
    @(posedge clk_sys_i) #1 pin = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1 mode = t16_pkg::MODE_CTC_CAP;
    pin = 1'b1;
    u_core.wr16(t16_pkg::OFS_CAP_L, 16'h0005);
    u_core.wr16(t16_pkg::OFS_CNT_L, 16'h0003);
    ticks(3);
    u_core.rd16(t16_pkg::OFS_CNT_L, v); `CHK("ctc top", 16'h0000, v)
    u_core.rd16(t16_pkg::OFS_CAP_L, v); `CHK("pin ignored", 16'h0005, v)
    u_core.rd8(t16_pkg::OFS_IRQ_FLG, b); `CHK("top flag", 8'h20, b)
    u_core.wr8(t16_pkg::OFS_IRQ_FLG, 8'h20);
    @(posedge clk_sys_i) #1 mode = t16_pkg::MODE_NORMAL;
  endtask : t_top
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    #200000 n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    t_reset();
    t_block_force();
    t_match();
    t_capture();
    t_top();
    print_verdict();
  end
endmodule : test_timer16_counter_compare_capture_regs
`default_nettype wire
